// file: pkg/gfs_consts.vh
// How it works
// - each of five pins has its own function select and carries that source
// - function select is seven bits wide and resets to 01h, button/logic level
// - pin five accepts only a subset of the function codes
// - code 00h gives audio interface frame clocks on pins 1-3; reserved on pin 4
// - code 01h drives output level when direction 0; input when direction 1
// - codes 02h and 03h drive interrupt lines one and two
// - code 04h drives the derived output clock
// - codes 05h and 06h drive loop one and loop two clocks
// - codes 08h and 09h drive pwm generators one and two
// - codes 0Ah and 0Bh drive system and asynchronous clock underclock errors
// - codes 0Ch and 0Dh drive loop one and two lock, high locked
// - codes 0Fh and 10h drive loop one and two clock active
// - code 12h drives high once headphone detection completed
// - code 13h drives high for 31 us after each accessory detect event
// - code 15h gives a short pulse when the write sequencer finishes
// - code 16h drives high on control interface address error
// - codes 17h, 18h, 19h drive input path overflow, filter and fifo errors
// - codes 1Ah and 1Bh drive rate converter one and two lock
// - code 1Ch drives high on rate converter configuration error
// - codes 1Dh-21h drive the five range controller one status flags
// - codes 22h-26h drive the same five flags for range controller two
// - code 27h drives high on mixer dropped sample
`ifndef GFS_CONSTS_VH
`define GFS_CONSTS_VH

`define GFS_NUM_PINS        5
`define GFS_FN_W            7
`define GFS_ADDR_W          8
`define GFS_DATA_W          32

// register offsets
`define GFS_PIN_CTRL_BASE   8'h00
`define GFS_PIN_STATUS_ADDR 8'h14

// pin control field positions
`define GFS_FN_LSB          0
`define GFS_FN_MSB          6
`define GFS_LVL_BIT         14
`define GFS_DIR_BIT         15

// reset values
`define GFS_FN_RESET        7'h01
`define GFS_DIR_RESET       1'b1
`define GFS_LVL_RESET       1'b0

// function codes
`define GFS_FN_FRAME_CLK    7'h00
`define GFS_FN_GPIO         7'h01
`define GFS_FN_INTERRUPT_LINE_ONE         7'h02
`define GFS_FN_INTERRUPT_LINE_TWO         7'h03
`define GFS_FN_DERIVED_OUTPUT_CLOCK        7'h04
`define GFS_FN_FREQ_LOCKED_LOOP_ONE_CLK     7'h05
`define GFS_FN_FREQ_LOCKED_LOOP_TWO_CLK     7'h06
`define GFS_FN_PWM1         7'h08
`define GFS_FN_PWM2         7'h09
`define GFS_FN_SYS_UNDER    7'h0A
`define GFS_FN_ASY_UNDER    7'h0B
`define GFS_FN_FREQ_LOCKED_LOOP_ONE_LOCK    7'h0C
`define GFS_FN_FREQ_LOCKED_LOOP_TWO_LOCK    7'h0D
`define GFS_FN_FREQ_LOCKED_LOOP_ONE_OK      7'h0F
`define GFS_FN_FREQ_LOCKED_LOOP_TWO_OK      7'h10
`define GFS_FN_HP_DET       7'h12
`define GFS_FN_ACC_DET      7'h13
`define GFS_FN_WSEQ_DONE    7'h15
`define GFS_FN_ADDR_ERR     7'h16
`define GFS_FN_ADC_OVF      7'h17
`define GFS_FN_ADC_CIC      7'h18
`define GFS_FN_ADC_FIFO     7'h19
`define GFS_FN_RC1_LOCK     7'h1A
`define GFS_FN_RC2_LOCK     7'h1B
`define GFS_FN_RC_CFG_ERR   7'h1C
`define GFS_FN_RNG1_FIRST   7'h1D
`define GFS_FN_RNG2_FIRST   7'h22
`define GFS_FN_MIX_DROP     7'h27

// timing
`define GFS_CLK_PERIOD_NS   4
`define GFS_ACC_PULSE_NS    31000
`define GFS_WSEQ_PULSE_NS   32
// pulse lengths in core_clk cycles: 31 us and 32 ns at 4 ns
`define GFS_ACC_PULSE_CYCLES  16'h1E46
`define GFS_WSEQ_PULSE_CYCLES 16'h0008

`endif

// file: verilog/gfs_pulse_gen.v
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// one-shot pulse of fixed length, restarted by each trigger
module gfs_pulse_gen
#(
    parameter CNT_W  = 16,
    parameter [CNT_W-1:0] LENGTH = 16'd1
)
(
    input  wire             core_clk,
    input  wire             rst_b,
    input  wire             trigger,
    output reg              pulse
);

reg  [CNT_W-1:0] remain;
wire [CNT_W-1:0] next_remain;

assign next_remain = trigger ? LENGTH :
                     (remain != {CNT_W{1'b0}}) ? remain - {{(CNT_W-1){1'b0}}, 1'b1} : remain;

always @(posedge core_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        remain <= {CNT_W{1'b0}};
        pulse  <= 1'b0;
    end
    else
    begin
        remain <= next_remain;
        pulse  <= (next_remain != {CNT_W{1'b0}});
    end
end

endmodule // gfs_pulse_gen

// file: verilog/gfs_function_mux.v
`timescale 1ns/10ps
`include "gfs_consts.vh"
////////////////////////////////////////////////////////////////////////////////
// function select multiplexer for five general-purpose pins
module gfs_function_mux
#(
    parameter NUM_PINS        = `GFS_NUM_PINS,
    parameter FN_W            = `GFS_FN_W,
    parameter PULSE_CNT_W     = 16,
    parameter [PULSE_CNT_W-1:0] ACC_PULSE_CYCLES  = `GFS_ACC_PULSE_CYCLES,
    parameter [PULSE_CNT_W-1:0] WSEQ_PULSE_CYCLES = `GFS_WSEQ_PULSE_CYCLES
)
(
    input  wire                     core_clk,
    input  wire                     rst_b,
    // register port
    input  wire [`GFS_ADDR_W-1:0]   reg_addr,
    input  wire [`GFS_DATA_W-1:0]   reg_wdata,
    input  wire                     reg_wr,
    input  wire                     reg_rd,
    output reg  [`GFS_DATA_W-1:0]   reg_rdata,
    // pins
    input  wire [NUM_PINS-1:0]      pin_in,
    output reg  [NUM_PINS-1:0]      pin_out,
    output wire [NUM_PINS-1:0]      pin_oe,
    output reg  [NUM_PINS-1:0]      pin_input_level,
    // sources
    input  wire                     audio_if1_tx_frame_clock,
    input  wire                     audio_if2_tx_frame_clock,
    input  wire                     audio_if3_tx_frame_clock,
    input  wire                     interrupt_line_one,
    input  wire                     interrupt_line_two,
    input  wire                     derived_output_clock,
    input  wire                     freq_locked_loop_one_clock,
    input  wire                     freq_locked_loop_two_clock,
    input  wire                     pwm_one,
    input  wire                     pwm_two,
    input  wire                     main_system_clock_underclocked,
    input  wire                     asynchronous_clock_underclocked,
    input  wire                     freq_locked_loop_one_lock,
    input  wire                     freq_locked_loop_two_lock,
    input  wire                     freq_locked_loop_one_clock_ok,
    input  wire                     freq_locked_loop_two_clock_ok,
    input  wire                     headphone_detect_done,
    input  wire                     accessory_detect_event,
    input  wire                     write_seq_done_event,
    input  wire                     ctrl_addr_error,
    input  wire                     adc_overflow_error,
    input  wire                     adc_decimation_error,
    input  wire                     adc_fifo_error,
    input  wire                     rate_converter_one_lock,
    input  wire                     rate_converter_two_lock,
    input  wire                     rate_converter_cfg_error,
    input  wire [4:0]               range_controller_one_status,
    input  wire [4:0]               range_controller_two_status,
    input  wire                     mixer_dropped_sample
);

////////////////////////////////////////////////////////////////////////////////
// helper functions

// pin five accepts only the codes listed here
function fn_allowed;
    input integer    pin;
    input [FN_W-1:0] code;
    begin
        if (pin != NUM_PINS - 1)
            fn_allowed = 1'b1;
        else
        begin
            case (code)
                `GFS_FN_GPIO,
                `GFS_FN_INTERRUPT_LINE_ONE,
                `GFS_FN_INTERRUPT_LINE_TWO,
                `GFS_FN_DERIVED_OUTPUT_CLOCK,
                `GFS_FN_FREQ_LOCKED_LOOP_ONE_CLK,
                `GFS_FN_FREQ_LOCKED_LOOP_TWO_CLK,
                `GFS_FN_PWM1,
                `GFS_FN_PWM2:
                    fn_allowed = 1'b1;
                default:
                    fn_allowed = 1'b0;
            endcase
        end
    end
endfunction

// decode of a register address to a pin index, or all ones when not a pin
function [2:0] pin_of_addr;
    input [`GFS_ADDR_W-1:0] addr;
    begin
        case (addr)
            `GFS_PIN_CTRL_BASE + 8'h00: pin_of_addr = 3'h0;
            `GFS_PIN_CTRL_BASE + 8'h04: pin_of_addr = 3'h1;
            `GFS_PIN_CTRL_BASE + 8'h08: pin_of_addr = 3'h2;
            `GFS_PIN_CTRL_BASE + 8'h0C: pin_of_addr = 3'h3;
            `GFS_PIN_CTRL_BASE + 8'h10: pin_of_addr = 3'h4;
            default:                    pin_of_addr = 3'h7;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// event stretchers

wire acc_pulse;
wire wseq_pulse;

gfs_pulse_gen
#(
    .CNT_W  (PULSE_CNT_W),
    .LENGTH (ACC_PULSE_CYCLES)
)
u_acc_pulse
(
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .trigger  (accessory_detect_event),
    .pulse    (acc_pulse)
);

gfs_pulse_gen
#(
    .CNT_W  (PULSE_CNT_W),
    .LENGTH (WSEQ_PULSE_CYCLES)
)
u_wseq_pulse
(
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .trigger  (write_seq_done_event),
    .pulse    (wseq_pulse)
);

////////////////////////////////////////////////////////////////////////////////
// source table indexed by function code

wire [127:0] src;

assign src[0]     = 1'b0;                                // pin specific, see below
assign src[1]     = 1'b0;                                // pin specific, see below
assign src[2]     = interrupt_line_one;
assign src[3]     = interrupt_line_two;
assign src[4]     = derived_output_clock;
assign src[5]     = freq_locked_loop_one_clock;
assign src[6]     = freq_locked_loop_two_clock;
assign src[7]     = 1'b0;
assign src[8]     = pwm_one;
assign src[9]     = pwm_two;
assign src[10]    = main_system_clock_underclocked;
assign src[11]    = asynchronous_clock_underclocked;
assign src[12]    = freq_locked_loop_one_lock;
assign src[13]    = freq_locked_loop_two_lock;
assign src[14]    = 1'b0;
assign src[15]    = freq_locked_loop_one_clock_ok;
assign src[16]    = freq_locked_loop_two_clock_ok;
assign src[17]    = 1'b0;
assign src[18]    = headphone_detect_done;
assign src[19]    = acc_pulse;
assign src[20]    = 1'b0;
assign src[21]    = wseq_pulse;
assign src[22]    = ctrl_addr_error;
assign src[23]    = adc_overflow_error;
assign src[24]    = adc_decimation_error;
assign src[25]    = adc_fifo_error;
assign src[26]    = rate_converter_one_lock;
assign src[27]    = rate_converter_two_lock;
assign src[28]    = rate_converter_cfg_error;
assign src[33:29] = range_controller_one_status;
assign src[38:34] = range_controller_two_status;
assign src[39]    = mixer_dropped_sample;
assign src[127:40] = {88{1'b0}};

// frame clock per pin for code 00h; the fourth and fifth have none
wire [NUM_PINS-1:0] frame_clk;

assign frame_clk = {2'b00,
                    audio_if3_tx_frame_clock,
                    audio_if2_tx_frame_clock,
                    audio_if1_tx_frame_clock};

////////////////////////////////////////////////////////////////////////////////
// pin control registers

reg  [FN_W-1:0]     pin_function_select [0:NUM_PINS-1];
reg  [NUM_PINS-1:0] pin_direction;
reg  [NUM_PINS-1:0] pin_output_level;
wire [2:0]          wr_pin;
wire [2:0]          rd_pin;
wire [FN_W-1:0]     wr_code;

assign wr_pin  = pin_of_addr(reg_addr);
assign rd_pin  = pin_of_addr(reg_addr);
assign wr_code = reg_wdata[`GFS_FN_MSB:`GFS_FN_LSB];

genvar gi;
generate
    for (gi = 0; gi < NUM_PINS; gi = gi + 1)
    begin : g_ctrl
        always @(posedge core_clk or negedge rst_b)
        begin
            if (!rst_b)
            begin
                pin_function_select[gi] <= `GFS_FN_RESET;
                pin_direction[gi]       <= `GFS_DIR_RESET;
                pin_output_level[gi]    <= `GFS_LVL_RESET;
            end
            else if (reg_wr && (wr_pin == gi))
            begin
                if (fn_allowed(gi, wr_code))
                    pin_function_select[gi] <= wr_code;
                pin_direction[gi]       <= reg_wdata[`GFS_DIR_BIT];
                pin_output_level[gi]    <= reg_wdata[`GFS_LVL_BIT];
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// output selection per pin

reg [NUM_PINS-1:0] next_pin_out;
integer            pi;

always @*
begin
    next_pin_out = {NUM_PINS{1'b0}};
    for (pi = 0; pi < NUM_PINS; pi = pi + 1)
    begin
        case (pin_function_select[pi])
            `GFS_FN_FRAME_CLK:
                next_pin_out[pi] = frame_clk[pi];
            `GFS_FN_GPIO:
                next_pin_out[pi] = pin_output_level[pi];
            default:
                next_pin_out[pi] = src[pin_function_select[pi]];
        endcase
    end
end

// direction 0 drives the pin, direction 1 leaves it an input
assign pin_oe = ~pin_direction;

always @(posedge core_clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        pin_out         <= {NUM_PINS{1'b0}};
        pin_input_level <= {NUM_PINS{1'b0}};
    end
    else
    begin
        pin_out         <= next_pin_out;
        pin_input_level <= pin_in;
    end
end

////////////////////////////////////////////////////////////////////////////////
// register read back

reg [`GFS_DATA_W-1:0] next_rdata;

always @*
begin
    next_rdata = {`GFS_DATA_W{1'b0}};
    if (reg_rd)
    begin
        if (reg_addr == `GFS_PIN_STATUS_ADDR)
            next_rdata[NUM_PINS-1:0] = pin_input_level;
        else if (rd_pin < NUM_PINS)
        begin
            next_rdata[`GFS_FN_MSB:`GFS_FN_LSB] = pin_function_select[rd_pin];
            next_rdata[`GFS_LVL_BIT]            = pin_output_level[rd_pin];
            next_rdata[`GFS_DIR_BIT]            = pin_direction[rd_pin];
        end
    end
end

always @(posedge core_clk or negedge rst_b)
begin
    if (!rst_b)
        reg_rdata <= {`GFS_DATA_W{1'b0}};
    else
        reg_rdata <= next_rdata;
end

endmodule // gfs_function_mux

// file: verilog/unused_placeholder_none.v
`timescale 1ns/10ps

// file: bench/gfs_mux_checker.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// watches pin one of the function mux through its ports
module gfs_mux_checker
(
    input wire logic        core_clk,
    input wire logic        rst_b,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic [4:0]  pin_out,
    input wire logic [4:0]  pin_oe,
    input wire logic        audio_if1_tx_frame_clock,
    input wire logic        interrupt_line_one,
    input wire logic        interrupt_line_two,
    input wire logic        accessory_detect_event,
    input wire logic        write_seq_done_event,
    input wire logic [4:0]  range_controller_one_status
);
    logic [6:0] fn1;
    logic       dir1;
    logic       lvl1;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////////
    // shadow of the pin one control word
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fn1  <= 7'h01;
            dir1 <= 1'h1;
            lvl1 <= 1'h0;
        end
        else if (reg_wr && reg_addr == 8'h00)
        begin
            fn1  <= reg_wdata[6:0];
            dir1 <= reg_wdata[15];
            lvl1 <= reg_wdata[14];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    sequence s_high8;
        pin_out[0] [*8];
    endsequence
    sequence s_pulse8;
        s_high8 ##1 !pin_out[0];
    endsequence
    a_reset_idle: assert property ($rose(rst_b) |-> pin_oe == 5'h00)
        else $error("pins driven after reset");
    a_oe_dir: assert property (pin_oe[0] == !dir1)
        else $error("pin one enable does not follow direction");
    a_level_drive: assert property ($past(fn1) == 7'h01 && !$past(dir1) |-> pin_out[0] == $past(lvl1))
        else $error("pin one level wrong");
    a_frame_clk: assert property ($past(fn1) == 7'h00 |-> pin_out[0] == $past(audio_if1_tx_frame_clock))
        else $error("pin one frame clock wrong");
    a_irq_one: assert property ($past(fn1) == 7'h02 |-> pin_out[0] == $past(interrupt_line_one))
        else $error("pin one interrupt one wrong");
    a_irq_two: assert property ($past(fn1) == 7'h03 |-> pin_out[0] == $past(interrupt_line_two))
        else $error("pin one interrupt two wrong");
    a_reserved_low: assert property ($past(fn1) inside {7'h07, 7'h0E, 7'h11, 7'h14, 7'h28} |-> !pin_out[0])
        else $error("reserved code drives high");
    a_range_one: assert property ($past(fn1) inside {[7'h1D:7'h21]} |->
        pin_out[0] == $past(range_controller_one_status[fn1 - 7'h1D]))
        else $error("range flag wrong");
    a_acc_pulse: assert property (fn1 == 7'h13 && $past(fn1) == 7'h13 && accessory_detect_event |-> ##2 s_high8)
        else $error("detect pulse too short");
    a_wseq_pulse: assert property (fn1 == 7'h15 && $past(fn1) == 7'h15 && write_seq_done_event |-> ##2 s_pulse8)
        else $error("sequencer pulse wrong length");
endmodule // gfs_mux_checker

// file: bench/gfs_pin_host.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// far side of the pins: host level where the device does not drive
module gfs_pin_host
(
    input  wire logic [4:0] pin_out,
    input  wire logic [4:0] pin_oe,
    input  wire logic [4:0] host_lvl,
    output wire logic [4:0] pin_in
);
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & host_lvl);
endmodule // gfs_pin_host

// file: bench/gpio_function_select_mux_tb_top.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected %s exp %0h got %0h", n, e, g); end end
////////////////////////////////////////////////////////////////////////////////
module gpio_function_select_mux_tb_top;
    logic        core_clk = 1'h0;
    logic        rst_b = 1'h0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'h0;
    logic        reg_rd = 1'h0;
    logic [31:0] reg_rdata;
    logic [31:0] d;
    logic [4:0]  pin_in;
    logic [4:0]  pin_out;
    logic [4:0]  pin_oe;
    logic [4:0]  pin_level;
    logic [4:0]  host_lvl = 5'h00;
    logic [36:0] s = 37'h0;
    int          bad_count = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    gfs_function_mux #(.ACC_PULSE_CYCLES(16'h0014), .WSEQ_PULSE_CYCLES(16'h0008)) i_dut (
        .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_input_level(pin_level), .audio_if1_tx_frame_clock(s[0]), .audio_if2_tx_frame_clock(s[1]),
        .audio_if3_tx_frame_clock(s[2]), .interrupt_line_one(s[3]), .interrupt_line_two(s[4]),
        .derived_output_clock(s[5]), .freq_locked_loop_one_clock(s[6]), .freq_locked_loop_two_clock(s[7]),
        .pwm_one(s[8]), .pwm_two(s[9]), .main_system_clock_underclocked(s[10]),
        .asynchronous_clock_underclocked(s[11]), .freq_locked_loop_one_lock(s[12]),
        .freq_locked_loop_two_lock(s[13]), .freq_locked_loop_one_clock_ok(s[14]),
        .freq_locked_loop_two_clock_ok(s[15]), .headphone_detect_done(s[16]), .accessory_detect_event(s[17]),
        .write_seq_done_event(s[18]), .ctrl_addr_error(s[19]), .adc_overflow_error(s[20]),
        .adc_decimation_error(s[21]), .adc_fifo_error(s[22]), .rate_converter_one_lock(s[23]),
        .rate_converter_two_lock(s[24]), .rate_converter_cfg_error(s[25]),
        .range_controller_one_status(s[30:26]), .range_controller_two_status(s[35:31]),
        .mixer_dropped_sample(s[36]));
    gfs_pin_host i_host (.pin_out(pin_out), .pin_oe(pin_oe), .host_lvl(host_lvl), .pin_in(pin_in));
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            bad_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("compares %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic setsrc(input logic [36:0] v);
        @(posedge core_clk);
        s <= v;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'h1;
        @(posedge core_clk);
        reg_wr    <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'h1;
        @(posedge core_clk);
        reg_rd   <= 1'h0;
        #1 d = reg_rdata;
    endtask
    // source index for a code, -1 for static low, -2 for event pulses
    function automatic int src_of(input int p, input logic [6:0] c);
        if (c == 7'h00) return (p < 3) ? p : -1;
        if (c >= 7'h02 && c <= 7'h06) return c + 1;
        if (c >= 7'h08 && c <= 7'h0D) return c;
        if (c == 7'h0F || c == 7'h10) return c - 1;
        if (c == 7'h12) return 16;
        if (c == 7'h13 || c == 7'h15) return -2;
        if (c >= 7'h16 && c <= 7'h27) return c - 3;
        return -1;
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        `CHK("oe", 5'h00, pin_oe)
        `CHK("out", 5'h00, pin_out)
        for (int p = 0; p < 5; p++)
        begin
            rd(8'(p * 4));
            `CHK("ctrl", 32'h0000_8001, d)
        end
        rd(8'h20);
        `CHK("unmapped", 32'h0, d)
        $display("test reset done");
    endtask
    task automatic t_gpio();
        for (int v = 1; v >= 0; v--)
        begin
            @(posedge core_clk);
            host_lvl <= {3'h0, v[0], 1'h0};
            wr(8'h00, {17'h0, v[0], 14'h0001});
            tick(3);
            `CHK("drive", {1'h1, v[0]}, {pin_oe[0], pin_out[0]})
            rd(8'h14);
            `CHK("input", v[0], d[1])
            `CHK("level in", v[0], pin_level[1])
            tick(1);
            `CHK("rdata idle", 32'h0, reg_rdata)
        end
        $display("test level done");
    endtask
    task automatic t_rerst();
        wr(8'h04, 32'h0000_0002);
        @(posedge core_clk);
        rst_b <= 1'h0;
        tick(3);
        `CHK("oe in reset", 5'h00, pin_oe)
        @(posedge core_clk);
        rst_b <= 1'h1;
        tick(1);
        `CHK("out after reset", 5'h00, pin_out)
        rd(8'h04);
        `CHK("ctrl after reset", 32'h0000_8001, d)
        $display("test reset again done");
    endtask
    task automatic t_codes();
        logic [6:0] c;
        logic [6:0] kept;
        int         x;
        for (int p = 0; p < 5; p++)
        begin
            kept = 7'h01;
            for (int k = 0; k <= 40; k++)
            begin
                c = k[6:0];
                setsrc(37'h0);
                wr(8'(p * 4), {25'h0, c});
                if (p < 4 || c inside {[7'h01:7'h06], 7'h08, 7'h09}) kept = c;
                x = src_of(p, kept);
                if (x == -2) continue;
                setsrc(x < 0 ? ~37'h0 : 37'h1 << x);
                tick(3);
                `CHK("pin high", 1'(x >= 0), pin_out[p])
                setsrc(x < 0 ? 37'h0 : ~(37'h1 << x));
                tick(3);
                `CHK("pin low", 1'h0, pin_out[p])
            end
        end
        $display("test codes done");
    endtask
    task automatic t_pulse(input logic [6:0] c, input int b, input int n);
        int cnt = 0;
        setsrc(37'h0);
        wr(8'h00, {25'h0, c});
        tick(2);
        setsrc(37'h1 << b);
        setsrc(37'h0);
        repeat (40)
        begin
            tick(1);
            cnt += pin_out[0];
        end
        `CHK("pulse", n, cnt)
        $display("test pulse done");
    endtask
    initial
    begin
        repeat (8) @(posedge core_clk);
        rst_b <= 1'h1;
        tick(1);
        t_reset();
        t_gpio();
        t_codes();
        t_pulse(7'h13, 17, 20);
        t_pulse(7'h15, 18, 8);
        t_rerst();
        stop_test();
    end
endmodule // gpio_function_select_mux_tb_top
bind gfs_function_mux gfs_mux_checker i_chk (
    .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .pin_out(pin_out), .pin_oe(pin_oe), .audio_if1_tx_frame_clock(audio_if1_tx_frame_clock),
    .interrupt_line_one(interrupt_line_one), .interrupt_line_two(interrupt_line_two),
    .accessory_detect_event(accessory_detect_event), .write_seq_done_event(write_seq_done_event),
    .range_controller_one_status(range_controller_one_status));
